//--- pkg/adc_prescale_pkg.sv
// shared constants and types for the conversion-clock prescaler and mux addressing
package adc_prescale_pkg;

    // prescaler counter and field widths
    localparam int CNT_W     = 5;
    localparam int LOW_W     = 3;
    localparam int RUN_W     = 8;

    // conversion command channel field and external mux addressing
    localparam int CH_W      = 6;
    localparam int ADDR_W    = 3;
    localparam int EXT_SEL_W = 2;

    // counter values
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;
    localparam logic [RUN_W-1:0] RUN_ONE  = 8'h01;

    // reset values
    localparam logic [LOW_W-1:0]     LOW_RST  = 3'h0;
    localparam logic [ADDR_W-1:0]    ADDR_RST = 3'h0;
    localparam logic [EXT_SEL_W-1:0] SEL_RST  = 2'h0;
    localparam logic [CH_W-1:0]      CH_RST   = 6'h00;

    // channel field layout in external mode: [4:3] picks the mux, [2:0] its input
    localparam int CH_ADDR_LSB = 0;
    localparam int CH_SEL_LSB  = 3;
    localparam int CH_EXT_BIT  = 5;  // set means an internal channel above the external range

    // prescaler phase machine
    typedef enum logic [2:0] {
        ST_LOAD = 3'b001,
        ST_HIGH = 3'b010,
        ST_LOW  = 3'b100
    } phase_e;

endpackage

//--- src/half_cycle_stretch.sv
// holds a falling edge back by half a system clock period
`timescale 1ns/1ps
module half_cycle_stretch (
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic level_in,
    input  wire logic stretch_en,
    output logic      level_out
);

    logic neg_d;
    logic neg_q;

    // copy of the level taken on the falling system edge
    always_comb begin
        neg_d = level_in;
    end

    always_ff @(negedge core_clk) begin
        if (!rstn) begin
            neg_q <= 1'b0;
        end else begin
            neg_q <= neg_d;
        end
    end

    // the or only extends a high level; rising edges still come from the posedge flop
    assign level_out = level_in | (stretch_en & neg_q);

endmodule

//--- src/adc_clock_prescaler_ext_mux.sv
// conversion-clock prescaler and external analog mux addressing
`timescale 1ns/1ps
module adc_clock_prescaler_ext_mux
    import adc_prescale_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rstn,
    input  wire logic [CNT_W-1:0]     high_phase_count,
    input  wire logic [LOW_W-1:0]     low_phase_count,
    input  wire logic                 half_tick_add,
    input  wire logic                 external_mux_select,
    input  wire logic                 cmd_valid,
    input  wire logic [CH_W-1:0]      cmd_channel,
    output logic                      converter_clock,
    output logic [ADDR_W-1:0]         mux_address_out,
    output logic [EXT_SEL_W-1:0]      ext_input_sel,
    output logic                      ext_channel_active,
    output logic [CH_W-1:0]           internal_channel,
    output logic                      conversion_start
);

    // ------------------------------------------------------------------
    // prescaler state
    // ------------------------------------------------------------------
    phase_e           phase_d;
    phase_e           phase_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] high_d;
    logic [CNT_W-1:0] high_q;
    logic [LOW_W-1:0] low_d;
    logic [LOW_W-1:0] low_q;
    logic             half_d;
    logic             half_q;
    logic             clk_d;
    logic             clk_q;
    logic             low_match;

    // the low phase keeps counting down from zero, so its low bits run 111, 110, ...
    assign low_match = (cnt_q[LOW_W-1:0] == ~low_q);

    // next-state for the phase machine; settings are latched at the start of
    // each high phase so a write mid-period cannot produce a runt pulse
    always_comb begin
        phase_d = phase_q;
        cnt_d   = cnt_q;
        high_d  = high_q;
        low_d   = low_q;
        half_d  = half_q;
        clk_d   = clk_q;
        case (phase_q)
            ST_LOAD: begin
                phase_d = ST_HIGH;
                cnt_d   = high_phase_count;
                high_d  = high_phase_count;
                low_d   = low_phase_count;
                half_d  = half_tick_add;
                clk_d   = 1'b1;
            end
            ST_HIGH: begin
                cnt_d = cnt_q - CNT_ONE;
                if (cnt_q == CNT_ZERO) begin
                    phase_d = ST_LOW;
                    clk_d   = 1'b0;
                end
            end
            ST_LOW: begin
                if (low_match) begin
                    phase_d = ST_HIGH;
                    cnt_d   = high_phase_count;
                    high_d  = high_phase_count;
                    low_d   = low_phase_count;
                    half_d  = half_tick_add;
                    clk_d   = 1'b1;
                end else begin
                    cnt_d = cnt_q - CNT_ONE;
                end
            end
            default: begin
                phase_d = ST_LOAD;
                clk_d   = 1'b0;
            end
        endcase
    end

    // reset parks in the load state, which fetches the counts one cycle later
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            phase_q <= ST_LOAD;
            cnt_q   <= CNT_ZERO;
            high_q  <= CNT_ZERO;
            low_q   <= LOW_RST;
            half_q  <= 1'b0;
            clk_q   <= 1'b0;
        end else begin
            phase_q <= phase_d;
            cnt_q   <= cnt_d;
            high_q  <= high_d;
            low_q   <= low_d;
            half_q  <= half_d;
            clk_q   <= clk_d;
        end
    end

    // the stretch needs the falling system edge; this is the one output that
    // is not a plain posedge flop, traded for the half-period resolution
    half_cycle_stretch u_stretch (
        .core_clk   (core_clk),
        .rstn       (rstn),
        .level_in   (clk_q),
        .stretch_en (half_q),
        .level_out  (converter_clock)
    );

    // ------------------------------------------------------------------
    // channel addressing
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0]    addr_d;
    logic [ADDR_W-1:0]    addr_q;
    logic [EXT_SEL_W-1:0] sel_d;
    logic [EXT_SEL_W-1:0] sel_q;
    logic                 ext_d;
    logic                 ext_q;
    logic [CH_W-1:0]      ich_d;
    logic [CH_W-1:0]      ich_q;
    logic                 start_d;
    logic                 start_q;

    // true when a channel number lands on one of the external mux inputs
    function automatic logic is_external(input logic mode, input logic [CH_W-1:0] ch);
        is_external = mode && !ch[CH_EXT_BIT];
    endfunction

    // a command updates the address in the same cycle it is started, so the
    // external mux has the whole sample window to settle
    always_comb begin
        addr_d  = addr_q;
        sel_d   = sel_q;
        ext_d   = ext_q;
        ich_d   = ich_q;
        start_d = cmd_valid;
        if (cmd_valid) begin
            if (is_external(external_mux_select, cmd_channel)) begin
                ext_d  = 1'b1;
                addr_d = cmd_channel[CH_SEL_LSB-1:CH_ADDR_LSB];
                sel_d  = cmd_channel[CH_EXT_BIT-1:CH_SEL_LSB];
                ich_d  = CH_RST;
            end else begin
                ext_d  = 1'b0;
                addr_d = ADDR_RST;
                sel_d  = SEL_RST;
                ich_d  = cmd_channel;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            addr_q  <= ADDR_RST;
            sel_q   <= SEL_RST;
            ext_q   <= 1'b0;
            ich_q   <= CH_RST;
            start_q <= 1'b0;
        end else begin
            addr_q  <= addr_d;
            sel_q   <= sel_d;
            ext_q   <= ext_d;
            ich_q   <= ich_d;
            start_q <= start_d;
        end
    end

    assign mux_address_out    = addr_q;
    assign ext_input_sel      = sel_q;
    assign ext_channel_active = ext_q;
    assign internal_channel   = ich_q;
    assign conversion_start   = start_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [RUN_W-1:0] run_d;
    logic [RUN_W-1:0] run_q;

    // counts how many cycles the posedge clock level has held, one on its first cycle
    always_comb begin
        if (clk_d != clk_q) begin
            run_d = RUN_ONE;
        end else begin
            run_d = run_q + RUN_ONE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            run_q <= RUN_ONE;
        end else begin
            run_q <= run_d;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence high_ends_s;
        (phase_q == ST_HIGH) && (cnt_q == CNT_ZERO);
    endsequence

    sequence low_ends_s;
        (phase_q == ST_LOW) && low_match;
    endsequence

    high_load_a: assert property (
        $rose(clk_q) |-> (cnt_q == high_q) && (phase_q == ST_HIGH))
        else $error("counter not loaded with high count at high start");

    zero_low_a: assert property (
        high_ends_s |=> !clk_q && (phase_q == ST_LOW))
        else $error("clock not low after counter reached zero");

    high_len_a: assert property (
        high_ends_s |-> run_q == {3'h0, high_q} + RUN_ONE)
        else $error("high phase length wrong");

    low_len_a: assert property (
        low_ends_s |-> run_q == {5'h00, low_q} + RUN_ONE)
        else $error("low phase length wrong");

    low_end_a: assert property (
        (phase_q == ST_LOW) && !low_match |=> !clk_q)
        else $error("low phase ended without a match");

    reload_hi_a: assert property (
        low_ends_s |=> clk_q ##1 clk_q || (phase_q == ST_LOW))
        else $error("clock not restarted after low phase");

    run_free_a: assert property (
        $fell(clk_q) |-> ##[1:8] $rose(clk_q))
        else $error("converter clock stalled");

    stretch_a: assert property (
        $fell(clk_q) && half_q |-> !converter_clock)
        else $error("stretched edge still high at next posedge");

    ext_addr_a: assert property (
        cmd_valid && is_external(external_mux_select, cmd_channel)
        |=> ext_channel_active
            && (mux_address_out == $past(cmd_channel[CH_SEL_LSB-1:CH_ADDR_LSB]))
            && (ext_input_sel == $past(cmd_channel[CH_EXT_BIT-1:CH_SEL_LSB])))
        else $error("external address not taken from channel field");

    int_only_a: assert property (
        cmd_valid && !external_mux_select
        |=> !ext_channel_active && (internal_channel == $past(cmd_channel)))
        else $error("internal mode produced an external selection");

    int_addr_a: assert property (
        cmd_valid && !is_external(external_mux_select, cmd_channel)
        |=> (mux_address_out == ADDR_RST) && (ext_input_sel == SEL_RST))
        else $error("internal channel left an external address behind");

    ext_rise_a: assert property (
        $rose(ext_channel_active) |-> $past(cmd_valid && external_mux_select))
        else $error("external mode entered without the select bit");

    start_same_a: assert property (
        cmd_valid |=> conversion_start ##1 (conversion_start == $past(cmd_valid)))
        else $error("conversion start differs between channel kinds");

    start_once_a: assert property (
        !cmd_valid |=> !conversion_start)
        else $error("conversion start without a command");

    // between commands the addressing outputs hold, so the mux input stays put
    addr_hold_a: assert property (
        !cmd_valid |=> $stable(mux_address_out) && $stable(ext_input_sel)
            && $stable(ext_channel_active) && $stable(internal_channel))
        else $error("addressing changed without a command");

    // the counter steps down by one each cycle of the high phase
    high_step_a: assert property (
        (phase_q == ST_HIGH) && (cnt_q != CNT_ZERO)
        |=> clk_q && (cnt_q == $past(cnt_q) - CNT_ONE))
        else $error("high phase counter did not step down");

    low_start_a: assert property (
        high_ends_s |=> (cnt_q[LOW_W-1:0] == '1))
        else $error("low phase did not start from all ones");

    // sampled on the falling system edge, where the stretched level is visible
    fall_level_a: assert property (
        @(negedge core_clk) disable iff (!rstn)
        $fell(clk_q) |-> (converter_clock == half_q))
        else $error("falling edge not held back by the half tick");

endmodule

//--- bench/ext_mux_bank_model.sv
// behavioural bank of four eight-input analog muxes on the shared address lines
`timescale 1ns/1ps
module ext_mux_bank_model
    import adc_prescale_pkg::*;
(
    input  wire logic [ADDR_W-1:0] mux_address_out,
    output logic      [7:0]        ext_mux_input_a,
    output logic      [7:0]        ext_mux_input_b,
    output logic      [7:0]        ext_mux_input_c,
    output logic      [7:0]        ext_mux_input_d
);
    // every source carries a code built from its mux and input number, so a wrong
    // address or a wrong mux shows as a different code rather than a lucky match
    always_comb begin
        ext_mux_input_a = 8'h5a ^ {3'h0, 2'h0, mux_address_out};
        ext_mux_input_b = 8'h5a ^ {3'h0, 2'h1, mux_address_out};
        ext_mux_input_c = 8'h5a ^ {3'h0, 2'h2, mux_address_out};
        ext_mux_input_d = 8'h5a ^ {3'h0, 2'h3, mux_address_out};
    end
endmodule

//--- bench/adc_clock_prescaler_ext_mux_tb.sv
// self-checking bench for the conversion-clock prescaler and mux addressing
`timescale 1ns/1ps
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module adc_clock_prescaler_ext_mux_tb
    import adc_prescale_pkg::*;
;
    logic              core_clk;
    logic              rstn;
    logic [CNT_W-1:0]  high_phase_count;
    logic [LOW_W-1:0]  low_phase_count;
    logic              half_tick_add;
    logic              external_mux_select;
    logic              cmd_valid;
    logic [CH_W-1:0]   cmd_channel;
    logic              converter_clock;
    logic [ADDR_W-1:0] mux_address_out;
    logic [1:0]        ext_input_sel;
    logic              ext_channel_active;
    logic [CH_W-1:0]   internal_channel;
    logic              conversion_start;
    logic [7:0]        mux_out [4];
    logic [19:0]       notes [$];
    logic [19:0]       note;
    logic [31:0]       periods [$];
    logic [31:0]       pnote;
    realtime           t_rise;
    realtime           t_fall;
    bit                armed;
    logic [31:0]       seed;
    int                fail_count;
    int                n_tests;

    adc_clock_prescaler_ext_mux uut (
        .core_clk           (core_clk),
        .rstn               (rstn),
        .high_phase_count   (high_phase_count),
        .low_phase_count    (low_phase_count),
        .half_tick_add      (half_tick_add),
        .external_mux_select(external_mux_select),
        .cmd_valid          (cmd_valid),
        .cmd_channel        (cmd_channel),
        .converter_clock    (converter_clock),
        .mux_address_out    (mux_address_out),
        .ext_input_sel      (ext_input_sel),
        .ext_channel_active (ext_channel_active),
        .internal_channel   (internal_channel),
        .conversion_start   (conversion_start)
    );

    ext_mux_bank_model mux_bank (
        .mux_address_out(mux_address_out),
        .ext_mux_input_a(mux_out[0]),
        .ext_mux_input_b(mux_out[1]),
        .ext_mux_input_c(mux_out[2]),
        .ext_mux_input_d(mux_out[3])
    );

    // free-running system clock, 8 ns period
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // expected {ext, sel, addr, internal, analog code}; channels 32..63 stay internal
    function automatic logic [19:0] expect_of(input logic mux, input logic [5:0] ch);
        if (mux && !ch[5]) begin
            return {1'b1, ch[4:3], ch[2:0], 6'h00, 8'h5a ^ {3'h0, ch[4:0]}};
        end
        return {1'b0, 2'h0, 3'h0, ch, 8'h00};
    endfunction

    // new settings only take hold at a high start, so the period after the next rise is noted
    task automatic run_setting(input logic [4:0] h, input logic [2:0] l, input logic a);
        logic [15:0] hi2;
        logic [15:0] lo2;
        hi2 = 16'(8 * (2 + 2 * int'(h) + int'(a)));
        lo2 = 16'(8 * (2 + 2 * int'(l) - int'(a)));
        @(posedge core_clk);
        high_phase_count <= h;
        low_phase_count  <= l;
        half_tick_add    <= a;
        @(posedge converter_clock);
        @(posedge core_clk);
        periods.push_back({hi2, lo2});
        while (periods.size() != 0) @(posedge core_clk);
    endtask

    // each high start closes the period armed at the one before and compares it
    always @(posedge converter_clock) begin
        if (armed) begin
            pnote = periods.pop_front();
            `CHECK(16'(int'((t_fall - t_rise) * 2.0)), pnote[31:16])
            `CHECK(16'(int'(($realtime - t_fall) * 2.0)), pnote[15:0])
        end
        armed = (periods.size() != 0);
        t_rise = $realtime;
    end

    always @(negedge converter_clock) begin
        t_fall = $realtime;
    end

    // one command per call; calls may follow each other on consecutive edges
    task automatic send(input logic mux, input logic [5:0] ch);
        @(posedge core_clk);
        cmd_valid           <= 1'b1;
        cmd_channel         <= ch;
        external_mux_select <= mux;
        notes.push_back(expect_of(mux, ch));
    endtask

    // a start pulse pairs with the oldest note; an unpaired pulse is a mismatch
    always @(posedge core_clk) begin
        if (conversion_start === 1'b1) begin
            if (notes.size() == 0) begin
                `CHECK(1'b1, 1'b0)
            end else begin
                note = notes.pop_front();
                `CHECK({ext_channel_active, ext_input_sel, mux_address_out, internal_channel}, note[19:8])
                if (note[19]) `CHECK(mux_out[note[18:17]], note[7:0])
            end
        end
    end

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // the whole run needs a few hundred cycles; far past that means a hang
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        wrap_up();
    end

    initial begin
        logic [31:0] r;
        logic [5:0]  edges [6];
        edges = '{6'h00, 6'h07, 6'h08, 6'h1f, 6'h20, 6'h3f};
        seed = 32'h80226e82;
        fail_count = 0;
        n_tests = 0;
        rstn = 1'b0;
        high_phase_count = 5'h01;
        low_phase_count = 3'h0;
        half_tick_add = 1'b0;
        external_mux_select = 1'b0;
        cmd_valid = 1'b0;
        cmd_channel = 6'h00;
        repeat (6) @(posedge core_clk);
        `CHECK({converter_clock, ext_channel_active, conversion_start}, 3'h0)
        rstn <= 1'b1;
        // count extremes, the shortest low phase with the half tick, then random
        run_setting(5'h00, 3'h0, 1'b0);
        run_setting(5'h1f, 3'h7, 1'b1);
        run_setting(5'h01, 3'h0, 1'b1);
        run_setting(5'h00, 3'h7, 1'b0);
        repeat (2) begin
            r = xorshift();
            run_setting(r[4:0], r[7:5], r[8]);
        end
        // range boundaries in both modes, then random back-to-back commands
        for (int i = 0; i < 12; i++) begin
            send(i[0], edges[i >> 1]);
        end
        repeat (40) begin
            r = xorshift();
            send(r[6], r[5:0]);
        end
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        repeat (4) @(posedge core_clk);
        `CHECK(32'(notes.size()), 32'h0)
        wrap_up();
    end
endmodule
